// *** verilog/expander_host_pkg.sv ***
// Purpose: Shared constants for the host that drives the quasi-bidirectional I/O expander.
// Assumes: A 100 MHz system clock.
// Notes:   Every timing count is derived from a time in nanoseconds.
package expander_host_pkg;
  // System clock period.
  localparam int unsigned CLK_PERIOD_NS   = 10;
  // Least time of one quarter of the serial clock period.
  localparam int unsigned SCL_QUARTER_NS  = 625;
  // Least times round up to whole cycles.
  localparam int unsigned SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_W          = 16;
  // Number of pin inputs that pass the synchroniser: clock line, data line, interrupt line.
  localparam int unsigned SYNC_W          = 3;
  // Seven-bit slave address that the expander answers to, set by its strap pins.
  localparam logic [6:0]  DEV_ADDR_RESET  = 7'h20;
  // Value shifted out while the device transmits, so the data line stays released.
  localparam logic [7:0]  READ_FILL       = 8'hFF;
  // Bit counter value of the acknowledge slot that follows eight data bits.
  localparam logic [3:0]  ACK_SLOT        = 4'h8;
  localparam logic [3:0]  LAST_DATA_BIT   = 4'h7;
  // Quarter phases of one serial bit.
  localparam logic [1:0]  PH_LOW_A        = 2'h0;
  localparam logic [1:0]  PH_LOW_B        = 2'h1;
  localparam logic [1:0]  PH_HIGH_A       = 2'h2;
  localparam logic [1:0]  PH_HIGH_B       = 2'h3;
endpackage

// *** verilog/pin_sync.sv ***
// Purpose: Two-flop synchroniser for pins that arrive from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // Reset to all ones: the open-drain lines idle high.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '1;
      q    <= '1;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // pin_sync
`default_nettype wire

// *** verilog/quarter_tick.sv ***
// Purpose: Free-running divider that marks each quarter of the serial clock period.
// Assumes: N is at least one.
// Notes:   The tick is a one-cycle pulse every N cycles when N is two or more; with N of one it stays high.
`timescale 1ns/1ps
`default_nettype none
module quarter_tick #(
  parameter int unsigned N = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Output pulse
  output logic      tick
);
  logic [expander_host_pkg::TICK_W-1:0] cnt;
  logic [expander_host_pkg::TICK_W-1:0] next_cnt;
  logic                                 next_tick;

  always_comb
  begin
    next_tick = (cnt == expander_host_pkg::TICK_W'(N - 1));
    next_cnt  = next_tick ? '0 : cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt  <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule // quarter_tick
`default_nettype wire

// *** verilog/expander_host.sv ***
// Purpose: Serial-bus master that reads and writes an eight-pin quasi-bidirectional expander.
// Assumes: Open-drain lines with pull-ups; the expander is the only slave addressed.
// Notes:   One command is one byte; the first command of a transfer sends START and address.
//
// What this block does
// - Pins used as inputs are always written as ones before being read.
// - Reads begin with the address byte whose last bit is one; device then sends port.
// - After each read byte the master acknowledges for more, or refuses and stops.
// - One data bit per clock pulse; data changes only while the clock is low.
// - START is data falling with clock high; STOP is data rising with clock high.
// - Every byte has one acknowledge bit, driven low by the receiver on all but the last read byte.
// - The master refuses acknowledge on the last read byte; slave releases data.
// - Any number of bytes may pass between START and STOP.
// - A transfer starts only while the bus is not busy.
// - Every write carries ones in the positions of input pins.
// - Pins tied together are switched on or off together in one write.
`timescale 1ns/1ps
`default_nettype none
module expander_host #(
  parameter logic [6:0] DEV_ADDR = expander_host_pkg::DEV_ADDR_RESET
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Byte commands
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic       cmd_last,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_ready,
  // Pin roles on the expander
  input  wire logic [7:0] in_mask,
  input  wire logic [7:0] gang_mask,
  // Byte answers
  output logic            rsp_valid,
  output logic      [7:0] rsp_data,
  output logic            rsp_nack,
  // Serial clock line
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_n,
  // Serial data line
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  // Device interrupt line
  input  wire logic       int_n_i,
  output logic            irq
);
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_SHIFT, ST_WAIT, ST_STOP} state_e;

  logic [1:0] rst_q;
  logic       rst_sync;
  logic       tick;
  logic       scl_s;
  logic       sda_s;
  logic       int_s;
  logic       scl_prev;
  logic       sda_prev;
  logic       bus_busy;
  logic       next_bus_busy;
  state_e     state;
  state_e     next_state;
  logic [1:0] qph;
  logic [1:0] next_qph;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] cur_data;
  logic [7:0] next_cur_data;
  logic       is_addr;
  logic       next_is_addr;
  logic       cur_read;
  logic       next_cur_read;
  logic       cur_last;
  logic       next_cur_last;
  logic       next_cmd_ready;
  logic       next_rsp_valid;
  logic [7:0] next_rsp_data;
  logic       next_rsp_nack;
  logic       next_scl_oe_n;
  logic       next_sda_oe_n;
  logic [7:0] wr_shaped;

  // Reset is released through two flops so every flop leaves reset on the same edge.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_sync = rst_q[1];

  pin_sync #(
    .W (expander_host_pkg::SYNC_W)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_sync),
    .d     ({scl_i, sda_i, int_n_i}),
    .q     ({scl_s, sda_s, int_s})
  );

  quarter_tick #(
    .N (expander_host_pkg::SCL_QUARTER_CYC)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_sync),
    .tick  (tick)
  );

  // Tied pins follow each other: if any of them is to sink, all of them sink.
  function automatic logic [7:0] shape(input logic [7:0] d, input logic [7:0] im, input logic [7:0] gm);
    logic [7:0] g;
    g = d;
    if ((g & gm) != gm)
      g = g & ~gm;
    return g | im;
  endfunction

  assign wr_shaped = shape(cmd_data, in_mask, gang_mask);

  // Watches the lines for START and STOP from any master.
  always_comb
  begin
    next_bus_busy = bus_busy;
    if (scl_s && scl_prev && sda_prev && !sda_s)
      next_bus_busy = 1'b1;
    else if (scl_s && scl_prev && !sda_prev && sda_s)
      next_bus_busy = 1'b0;
  end

  always_comb
  begin
    next_state     = state;
    next_qph       = qph;
    next_bitcnt    = bitcnt;
    next_shreg     = shreg;
    next_cur_data  = cur_data;
    next_is_addr   = is_addr;
    next_cur_read  = cur_read;
    next_cur_last  = cur_last;
    next_cmd_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data;
    next_rsp_nack  = rsp_nack;
    next_scl_oe_n  = scl_oe_n;
    next_sda_oe_n  = sda_oe_n;
    case (state)
      ST_IDLE:
      begin
        next_scl_oe_n  = 1'b1;
        next_sda_oe_n  = 1'b1;
        next_cmd_ready = !bus_busy && scl_s && sda_s;
        if (cmd_valid && cmd_ready && !bus_busy)
        begin
          next_cmd_ready = 1'b0;
          next_cur_read  = cmd_read;
          next_cur_last  = cmd_last;
          next_cur_data  = wr_shaped;
          next_shreg     = {DEV_ADDR, cmd_read};
          next_is_addr   = 1'b1;
          next_qph       = expander_host_pkg::PH_LOW_A;
          next_state     = ST_START;
        end
      end
      ST_START:
      begin
        if (tick)
        begin
          if (qph == expander_host_pkg::PH_LOW_A)
          begin
            next_sda_oe_n = 1'b0;
            next_qph      = expander_host_pkg::PH_LOW_B;
          end
          else
          begin
            next_bitcnt = 4'h0;
            next_qph    = expander_host_pkg::PH_LOW_A;
            next_state  = ST_SHIFT;
          end
        end
      end
      ST_SHIFT:
      begin
        if (tick)
        begin
          case (qph)
            expander_host_pkg::PH_LOW_A:
            begin
              next_scl_oe_n = 1'b0;
              next_qph      = expander_host_pkg::PH_LOW_B;
            end
            expander_host_pkg::PH_LOW_B:
            begin
              // Data moves only here, a full quarter after the clock went low.
              if (bitcnt != expander_host_pkg::ACK_SLOT)
                next_sda_oe_n = shreg[7];
              else if (is_addr || !cur_read)
                next_sda_oe_n = 1'b1;
              else
                next_sda_oe_n = cur_last;
              next_qph = expander_host_pkg::PH_HIGH_A;
            end
            expander_host_pkg::PH_HIGH_A:
            begin
              next_scl_oe_n = 1'b1;
              next_qph      = expander_host_pkg::PH_HIGH_B;
            end
            default:
            begin
              // A slave that stretches the clock holds this phase until the line is high.
              if (scl_s && bitcnt != expander_host_pkg::ACK_SLOT)
              begin
                next_shreg  = {shreg[6:0], sda_s};
                next_bitcnt = bitcnt + 4'h1;
                next_qph    = expander_host_pkg::PH_LOW_A;
              end
              else if (scl_s && is_addr)
              begin
                next_qph = expander_host_pkg::PH_LOW_A;
                if (sda_s)
                begin
                  next_rsp_valid = 1'b1;
                  next_rsp_nack  = 1'b1;
                  next_rsp_data  = 8'h00;
                  next_state     = ST_STOP;
                end
                else
                begin
                  next_is_addr = 1'b0;
                  next_bitcnt  = 4'h0;
                  next_shreg   = cur_read ? expander_host_pkg::READ_FILL : cur_data;
                end
              end
              else if (scl_s)
              begin
                next_rsp_valid = 1'b1;
                next_rsp_data  = shreg;
                next_rsp_nack  = !cur_read && sda_s;
                next_qph       = expander_host_pkg::PH_LOW_A;
                if (cur_last || (!cur_read && sda_s))
                  next_state = ST_STOP;
                else
                begin
                  next_scl_oe_n = 1'b0;
                  next_state    = ST_WAIT;
                end
              end
            end
          endcase
        end
      end
      ST_WAIT:
      begin
        // The clock is held low between bytes, so a transfer can run on without limit.
        next_cmd_ready = !(cmd_valid && cmd_ready);
        if (cmd_valid && cmd_ready)
        begin
          next_cur_last = cmd_last;
          next_cur_data = wr_shaped;
          next_shreg    = cur_read ? expander_host_pkg::READ_FILL : wr_shaped;
          next_bitcnt   = 4'h0;
          next_qph      = expander_host_pkg::PH_LOW_B;
          next_state    = ST_SHIFT;
        end
      end
      ST_STOP:
      begin
        if (tick)
        begin
          case (qph)
            expander_host_pkg::PH_LOW_A:
            begin
              next_scl_oe_n = 1'b0;
              next_qph      = expander_host_pkg::PH_LOW_B;
            end
            expander_host_pkg::PH_LOW_B:
            begin
              next_sda_oe_n = 1'b0;
              next_qph      = expander_host_pkg::PH_HIGH_A;
            end
            expander_host_pkg::PH_HIGH_A:
            begin
              next_scl_oe_n = 1'b1;
              next_qph      = expander_host_pkg::PH_HIGH_B;
            end
            default:
            begin
              if (scl_s)
              begin
                next_sda_oe_n = 1'b1;
                next_state    = ST_IDLE;
              end
            end
          endcase
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      scl_prev  <= 1'b1;
      sda_prev  <= 1'b1;
      bus_busy  <= 1'b0;
      state     <= ST_IDLE;
      qph       <= expander_host_pkg::PH_LOW_A;
      bitcnt    <= 4'h0;
      shreg     <= 8'h00;
      cur_data  <= 8'hFF;
      is_addr   <= 1'b0;
      cur_read  <= 1'b0;
      cur_last  <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_nack  <= 1'b0;
      scl_o     <= 1'b0;
      sda_o     <= 1'b0;
      scl_oe_n  <= 1'b1;
      sda_oe_n  <= 1'b1;
      irq       <= 1'b0;
    end
    else
    begin
      scl_prev  <= scl_s;
      sda_prev  <= sda_s;
      bus_busy  <= next_bus_busy;
      state     <= next_state;
      qph       <= next_qph;
      bitcnt    <= next_bitcnt;
      shreg     <= next_shreg;
      cur_data  <= next_cur_data;
      is_addr   <= next_is_addr;
      cur_read  <= next_cur_read;
      cur_last  <= next_cur_last;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_data;
      rsp_nack  <= next_rsp_nack;
      scl_o     <= 1'b0;
      sda_o     <= 1'b0;
      scl_oe_n  <= next_scl_oe_n;
      sda_oe_n  <= next_sda_oe_n;
      irq       <= !int_s;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync);

  sequence stop_last_phase;
    state == ST_STOP && qph == expander_host_pkg::PH_HIGH_B && tick && scl_s;
  endsequence

  sequence bus_released;
    sda_oe_n && scl_oe_n && state == ST_IDLE;
  endsequence

  start_cond_a: assert property ((state == ST_START && qph == expander_host_pkg::PH_LOW_B) |-> (scl_oe_n && !sda_oe_n))
    else $error("START not made with clock released and data low");

  stop_cond_a: assert property (stop_last_phase |=> bus_released)
    else $error("STOP did not release data while clock high");

  data_stable_a: assert property (($changed(sda_oe_n) && $past(state) == ST_SHIFT) |-> !$past(scl_oe_n))
    else $error("Data line moved while clock released");

  busy_start_a: assert property ($rose(state == ST_START) |-> !$past(bus_busy))
    else $error("Transfer started on a busy bus");

  addr_rw_a: assert property ((state == ST_SHIFT && is_addr && bitcnt == expander_host_pkg::LAST_DATA_BIT
      && qph == expander_host_pkg::PH_HIGH_A) |-> (sda_oe_n == cur_read))
    else $error("Direction bit of address byte wrong");

  ack_last_a: assert property ((state == ST_SHIFT && !is_addr && cur_read && bitcnt == expander_host_pkg::ACK_SLOT
      && qph == expander_host_pkg::PH_HIGH_B) |-> (sda_oe_n == cur_last))
    else $error("Read acknowledge does not match last flag");

  ack_release_a: assert property ((state == ST_SHIFT && (is_addr || !cur_read) && bitcnt == expander_host_pkg::ACK_SLOT
      && qph == expander_host_pkg::PH_HIGH_B) |-> sda_oe_n)
    else $error("Master held data during slave acknowledge");

  input_ones_a: assert property ((state == ST_SHIFT && !is_addr && !cur_read && bitcnt == 4'h0
      && (in_mask & gang_mask) == 8'h00 && $stable(in_mask)) |-> ((shreg & in_mask) == in_mask))
    else $error("Input pin written as zero");

  gang_equal_a: assert property ((state == ST_SHIFT && !is_addr && !cur_read && bitcnt == 4'h0
      && (in_mask & gang_mask) == 8'h00 && $stable(gang_mask))
      |-> ((shreg & gang_mask) == 8'h00 || (shreg & gang_mask) == gang_mask))
    else $error("Tied pins written with different values");

  burst_wait_a: assert property ((state == ST_SHIFT && !cur_last && qph == expander_host_pkg::PH_HIGH_B
      && bitcnt == expander_host_pkg::ACK_SLOT && tick && scl_s && !is_addr && cur_read) |=> state == ST_WAIT)
    else $error("Acknowledged read did not continue");
endmodule // expander_host
`default_nettype wire

// *** verification/expander_dev_model.sv ***
// Purpose: Behavioural model of the eight-pin quasi-bidirectional expander on the serial bus.
// Assumes: Both serial lines have pull-ups; the model never stretches the clock.
// Notes:   The mute input makes the model refuse its address, for the refusal scenario only.
`timescale 1ns/1ps
`default_nettype none
module expander_dev_model #(
  parameter logic [6:0] ADDR = expander_host_pkg::DEV_ADDR_RESET
) (
  // Serial lines as seen on the wires
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull,
  // Scenario controls
  input  wire logic       mute,
  input  wire logic [7:0] ext_low,
  // Port, interrupt and bus event counts
  output logic      [7:0] pins,
  output logic            int_n,
  output int              start_cnt,
  output int              stop_cnt
);
  localparam logic [2:0] S_IDLE = 3'h0;
  localparam logic [2:0] S_ADDR = 3'h1;
  localparam logic [2:0] S_WR   = 3'h2;
  localparam logic [2:0] S_RD   = 3'h3;
  localparam logic [2:0] S_IGN  = 3'h4;

  logic [7:0] latch;
  logic [7:0] snap;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [3:0] bitc;
  logic [2:0] st;

  // Power-on leaves every pin a weak-high input with a snapshot of all ones, so a pin held low is flagged.
  initial
  begin
    latch     = 8'hFF;
    snap      = 8'hFF;
    tx        = 8'hFF;
    sh        = 8'h00;
    bitc      = 4'h0;
    st        = S_IDLE;
    sda_pull  = 1'b0;
    start_cnt = 0;
    stop_cnt  = 0;
  end

  // A pin reads its real level: the latch can only pull low, the outside world too.
  assign pins  = latch & ~ext_low;
  assign int_n = (pins == snap);

  always @(negedge sda)
    if (scl === 1'b1)
    begin
      st        = S_ADDR;
      bitc      = 4'hF;
      sda_pull  = 1'b0;
      start_cnt = start_cnt + 1;
    end

  // The latch is left alone, so outputs from the last acknowledge stay; a partial byte is lost.
  // Only a STOP that closes a transfer counts, so the lines settling at power-up are not taken for one.
  always @(posedge sda)
    if (scl === 1'b1 && st != S_IDLE)
    begin
      st       = S_IDLE;
      sda_pull = 1'b0;
      stop_cnt = stop_cnt + 1;
    end

  always @(posedge scl)
    if (st != S_IDLE && st != S_IGN)
    begin
      if (bitc < 4'h8)
      begin
        if (st != S_RD)
          sh = {sh[6:0], sda};
      end
      else if (st == S_RD)
      begin
        if (sda)
          st = S_IGN;
      end
      else if (st == S_WR && sda_pull)
      begin
        latch = sh;
        snap  = sh & ~ext_low;
      end
      else if (st == S_ADDR && sda_pull && sh[0])
        snap = pins;
    end

  always @(negedge scl)
    if (st != S_IDLE && st != S_IGN)
    begin
      if (bitc == 4'hF)
        bitc = 4'h0;
      else if (bitc < 4'h7)
      begin
        bitc     = bitc + 4'h1;
        sda_pull = (st == S_RD) && !tx[4'h7 - bitc];
      end
      else if (bitc == 4'h7)
      begin
        bitc     = 4'h8;
        sda_pull = (st == S_WR) || (st == S_ADDR && sh[7:1] == ADDR && !mute);
      end
      else
      begin
        bitc = 4'h0;
        if (st == S_ADDR)
          st = !sda_pull ? S_IGN : (sh[0] ? S_RD : S_WR);
        if (st == S_RD)
        begin
          tx   = pins;
          snap = pins;
        end
        sda_pull = (st == S_RD) && !tx[7];
      end
    end
endmodule // expander_dev_model
`default_nettype wire

// *** verification/expander_host_tb_top.sv ***
// Purpose: Self-checking bench for the expander host against a behavioural expander.
// Assumes: Serial lines and the interrupt line are pulled up; the host is the only master.
// Notes:   Full serial timing is kept, so each byte takes a few thousand clock cycles.
`timescale 1ns/1ps
`default_nettype none
module expander_host_tb_top;
  logic       clk;
  logic       rst_n;
  logic       cmd_valid;
  logic       cmd_read;
  logic       cmd_last;
  logic [7:0] cmd_data;
  logic       cmd_ready;
  logic [7:0] in_mask;
  logic [7:0] gang_mask;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_nack;
  logic       scl_o;
  logic       sda_o;
  logic       scl_oe_n;
  logic       sda_oe_n;
  logic       irq;
  logic       sda_pull;
  logic       int_n;
  logic       mute;
  logic [7:0] ext_low;
  logic [7:0] pins;
  int         start_cnt;
  int         stop_cnt;
  int         error_cnt;
  int         n_checks;
  wire        scl_w = scl_oe_n | scl_o;
  wire        sda_w = (sda_oe_n | sda_o) & ~sda_pull;

  expander_host uut (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_last(cmd_last),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .in_mask(in_mask), .gang_mask(gang_mask),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .int_n_i(int_n), .irq(irq));

  expander_dev_model dev (
    .scl(scl_w), .sda(sda_w), .sda_pull(sda_pull), .mute(mute), .ext_low(ext_low),
    .pins(pins), .int_n(int_n), .start_cnt(start_cnt), .stop_cnt(stop_cnt));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Offers one byte, holds it until taken, then waits for its answer.
  task automatic do_byte(input logic rd, input logic last, input logic [7:0] d,
                         output logic [7:0] got, output logic nk);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_last  <= last;
    cmd_data  <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 20000);
    cmd_valid <= 1'b0;
    check(n < 20000, 1'b1, "command taken in time");
    n = 0;
    do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 20000);
    got = rsp_data;
    nk  = rsp_nack;
    check(n < 20000, 1'b1, "byte answered in time");
  endtask

  // STOP is sent before the host is ready again, so this waits out the whole transfer.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 20000);
    check(n < 20000, 1'b1, "host idle again in time");
    repeat (6) @(posedge clk);
  endtask

  task automatic t_power_up();
    logic [7:0] d;
    logic       nk;
    repeat (8) @(posedge clk);
    check(irq, 1'b1, "irq after power-up");
    do_byte(1'b1, 1'b1, 8'h00, d, nk);
    check(nk, 1'b0, "address ack");
    check(d, 8'hFB, "power-up read");
    wait_idle();
    check(irq, 1'b0, "irq cleared by read");
    ext_low <= 8'h00;
    repeat (6) @(posedge clk);
    check(irq, 1'b1, "irq on rising pin");
    ext_low <= 8'h04;
    repeat (6) @(posedge clk);
    check(irq, 1'b0, "irq on return to snapshot");
    $display("test power_up done");
  endtask

  task automatic t_write_read();
    logic [7:0] d;
    logic       nk;
    ext_low <= 8'h00;
    do_byte(1'b0, 1'b1, 8'hA5, d, nk);
    check(nk, 1'b0, "write ack");
    check(d, 8'hA5, "write line levels");
    wait_idle();
    check(pins, 8'hA5, "pins after write");
    check(irq, 1'b0, "irq after write");
    ext_low <= 8'h01;
    repeat (6) @(posedge clk);
    check(irq, 1'b1, "irq on falling output pin");
    do_byte(1'b1, 1'b0, 8'h00, d, nk);
    check(d, 8'hA4, "first read byte");
    do_byte(1'b1, 1'b1, 8'h00, d, nk);
    check(d, 8'hA4, "second read byte");
    wait_idle();
    check(irq, 1'b0, "irq after read");
    $display("test write_read done");
  endtask

  task automatic t_masks();
    logic [7:0] d;
    logic       nk;
    in_mask   <= 8'h03;
    gang_mask <= 8'h30;
    do_byte(1'b0, 1'b0, 8'h10, d, nk);
    check(d, 8'h03, "ganged off with inputs high");
    do_byte(1'b0, 1'b1, 8'hF0, d, nk);
    check(d, 8'hF3, "ganged on with inputs high");
    wait_idle();
    check(pins, 8'hF2, "pins after two-byte write");
    in_mask   <= 8'h00;
    gang_mask <= 8'h00;
    $display("test masks done");
  endtask

  task automatic t_addr_nack();
    logic [7:0] d;
    logic       nk;
    mute <= 1'b1;
    do_byte(1'b1, 1'b0, 8'h00, d, nk);
    check(nk, 1'b1, "address refused");
    check(d, 8'h00, "data on refusal");
    wait_idle();
    mute <= 1'b0;
    check({scl_w, sda_w}, 2'h3, "idle bus lines");
    check({scl_o, sda_o}, 2'h0, "line drive levels");
    check(start_cnt, 32'h5, "start count");
    check(stop_cnt, 32'h5, "stop count");
    $display("test addr_nack done");
  endtask

  initial
  begin
    // The scenarios need about 30,000 cycles; this limit of 60,000 cycles is twice that.
    #600_000;
    error_cnt = error_cnt + 1;
    $display("MISMATCH t=%0t watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    rst_n     = 1'b0;
    cmd_valid = 1'b0;
    cmd_read  = 1'b0;
    cmd_last  = 1'b0;
    cmd_data  = 8'h00;
    in_mask   = 8'h00;
    gang_mask = 8'h00;
    mute      = 1'b0;
    ext_low   = 8'h04;
    error_cnt = 0;
    n_checks  = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_power_up();
    t_write_read();
    t_masks();
    t_addr_nack();
    report_and_stop();
  end
endmodule // expander_host_tb_top
`default_nettype wire
